// File: pcs_pkg.sv
// Function
// - Return stack holds sixteen entries of fifteen bits each.
// - Stack overflow or underflow sets its own flag in the power control status.
// - With stack reset option on, overflow or underflow also causes a software reset.
// - Interrupt entry saves context into shadow registers; return from interrupt restores it.
// - Two sixteen-bit indirect pointers reach all data and program memory.
// - Indirect access to program memory takes one extra instruction cycle.
// - Pointers give a linear view of general-purpose RAM across banks.
// - Program counter is fifteen bits over a 32K by 14 program space.
// - Addresses beyond implemented program memory wrap into the implemented space.
// - Reset starts at address zero; interrupts branch to address four.
// - Implemented program memory is 4096 or 8192 words by variant.
// - High-endurance region is the final 128 words, low byte only.
// - Pointer high-byte bit seven reads program memory low byte; writes there only set the program-write interrupt status bit.
`default_nettype none
package pcs_pkg;
  // Core widths
  localparam int PC_W = 15;
  localparam int STACK_DEPTH = 16;
  localparam int PTR_W = 16;
  localparam int DADDR_W = 12;
  localparam int PWORD_W = 14;
  localparam int CORE_CTX_W = 25;
  localparam int AXI_AW = 8;
  // Vectors and memory sizes
  localparam logic [14:0] RESET_VEC = 15'h0000;
  localparam logic [14:0] INT_VEC = 15'h0004;
  localparam int WORDS_SMALL = 4096;
  localparam int WORDS_LARGE = 8192;
  localparam int HEF_WORDS = 128;
  // Indirect pointer decoding
  localparam int PROG_SEL_BIT = 15;
  localparam logic [15:0] TRAD_LAST = 16'h0fff;
  localparam logic [15:0] LIN_BASE = 16'h2000;
  localparam logic [15:0] LIN_LAST = 16'h29af;
  localparam logic [11:0] GPR_BANK_BYTES = 12'h050;
  localparam logic [6:0] GPR_BANK_OFFSET = 7'h20;
  // Register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PWR_STATUS = 8'h04;
  localparam logic [7:0] REG_PC = 8'h08;
  localparam logic [7:0] REG_PTR0 = 8'h0c;
  localparam logic [7:0] REG_PTR1 = 8'h10;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h14;
  localparam logic [7:0] REG_IRQ_MASK = 8'h18;
  localparam logic [7:0] REG_STACK_DEPTH = 8'h1c;
  // Field positions
  localparam int CTRL_STKRST_BIT = 0;
  localparam int PWR_OVF_BIT = 0;
  localparam int PWR_UNF_BIT = 1;
  localparam int IRQ_OVF_BIT = 0;
  localparam int IRQ_UNF_BIT = 1;
  localparam int IRQ_PWRITE_BIT = 2;
  localparam int IRQ_W = 3;
  // Reset values
  localparam logic CTRL_RST = 1'b0;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Indirect access sequencer
  typedef enum logic [3:0] {
    IND_IDLE = 4'h1,
    IND_DATA = 4'h2,
    IND_PWAIT = 4'h4,
    IND_PCAP = 4'h8
  } pcs_ind_t;
endpackage
`default_nettype wire

// File: pcs_return_stack.sv
`timescale 1ns/10ps
`default_nettype none
module pcs_return_stack #(
  parameter int W = 15,
  parameter int DEPTH = 16
) (
  input wire logic clock, // Core clock
  input wire logic rst, // Synchronous reset
  input wire logic clear, // Empty the stack
  input wire logic push, // Push request
  input wire logic pop, // Pop request
  input wire logic [W-1:0] pushData, // Value to push
  output logic [W-1:0] top, // Top entry, zero when empty
  output logic [$clog2(DEPTH+1)-1:0] depth, // Entries held
  output logic overflow, // Push while full
  output logic underflow // Pop while empty
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [CW-1:0] count;
  } pcs_stack_t;

  pcs_stack_t s;
  pcs_stack_t next_s;

  // Full and empty events
  assign overflow = push && (s.count == CW'(DEPTH));
  assign underflow = pop && (s.count == '0);
  assign depth = s.count;
  assign top = (s.count == '0) ? '0 : s.mem[AW'(s.count - 1'b1)];

  // Push and pop bookkeeping
  always_comb begin
    next_s = s;
    if (clear) begin
      next_s.count = '0;
    end else if (push && !overflow) begin
      next_s.mem[s.count[AW-1:0]] = pushData;
      next_s.count = CW'(s.count + 1'b1);
    end else if (pop && !underflow) begin
      next_s.count = CW'(s.count - 1'b1);
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule // pcs_return_stack
`default_nettype wire

// File: pcs_shadow_ctx.sv
`timescale 1ns/10ps
`default_nettype none
module pcs_shadow_ctx #(
  parameter int W = 57
) (
  input wire logic clock, // Core clock
  input wire logic rst, // Synchronous reset
  input wire logic save, // Capture context
  input wire logic [W-1:0] saveData, // Live context
  output logic [W-1:0] shadow // Saved context
);
  typedef struct packed {
    logic [W-1:0] ctx;
  } pcs_shadow_t;

  pcs_shadow_t s;
  pcs_shadow_t next_s;

  assign shadow = s.ctx;

  // Capture on interrupt entry
  always_comb begin
    next_s = s;
    if (save) begin
      next_s.ctx = saveData;
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule // pcs_shadow_ctx
`default_nettype wire

// File: pcs_seq_unit.sv
`timescale 1ns/10ps
`default_nettype none
module pcs_seq_unit #(
  parameter bit LARGE_VARIANT = 1'b1 // 8192 words when set, 4096 otherwise
) (
  input wire logic clock, // Core clock, 100 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic [7:0] awaddr, // AXI write address
  input wire logic awvalid, // AXI write address valid
  output logic awready, // AXI write address ready
  input wire logic [31:0] wdata, // AXI write data
  input wire logic [3:0] wstrb, // AXI write strobes
  input wire logic wvalid, // AXI write data valid
  output logic wready, // AXI write data ready
  output logic [1:0] bresp, // AXI write response
  output logic bvalid, // AXI write response valid
  input wire logic bready, // AXI write response ready
  input wire logic [7:0] araddr, // AXI read address
  input wire logic arvalid, // AXI read address valid
  output logic arready, // AXI read address ready
  output logic [31:0] rdata, // AXI read data
  output logic [1:0] rresp, // AXI read response
  output logic rvalid, // AXI read data valid
  input wire logic rready, // AXI read data ready
  input wire logic opNext, // Advance to next instruction
  input wire logic opBranch, // Jump to branchTarget
  input wire logic opCall, // Call branchTarget
  input wire logic opReturn, // Return from subroutine
  input wire logic opRetfie, // Return from interrupt
  input wire logic intTake, // Interrupt accepted
  input wire logic [14:0] branchTarget, // Jump or call target
  input wire logic [24:0] ctxCore, // Live core registers
  output logic [24:0] restoreCore, // Core registers to restore
  output logic restoreValid, // Restore strobe
  output logic [14:0] pc, // Program counter
  input wire logic indReq, // Indirect access request
  input wire logic indWrite, // Request is a write
  input wire logic indSel, // Pointer 1 when set
  input wire logic [7:0] indWdata, // Indirect write data
  output logic [7:0] indRdata, // Indirect read data
  output logic indDone, // Indirect access finished
  output logic indBusy, // Indirect access in progress
  output logic [11:0] dataAddr, // Data memory address
  output logic dataRe, // Data memory read
  output logic dataWe, // Data memory write
  output logic [7:0] dataWdata, // Data memory write data
  input wire logic [7:0] dataRdata, // Data memory read data
  output logic [14:0] progAddr, // Program memory read address
  output logic progRe, // Program memory read
  output logic progHef, // Address in high-endurance region
  input wire logic [13:0] progData, // Program word, one cycle after progRe
  output logic softReset, // Stack error reset pulse
  output logic irq // Interrupt, level
);
  localparam int PROG_WORDS = LARGE_VARIANT ? pcs_pkg::WORDS_LARGE : pcs_pkg::WORDS_SMALL;
  localparam logic [14:0] PC_MASK = 15'(PROG_WORDS - 1);
  localparam logic [14:0] HEF_START = 15'(PROG_WORDS - pcs_pkg::HEF_WORDS);
  localparam int SW = pcs_pkg::CORE_CTX_W + 2 * pcs_pkg::PTR_W;

  typedef struct packed {
    logic [14:0] pc;
    logic stkRstEn;
    logic ovf;
    logic unf;
    logic softReset;
    logic [15:0] ptr0;
    logic [15:0] ptr1;
    logic [2:0] irqStat;
    logic [2:0] irqMask;
    logic irq;
    logic [24:0] restoreCore;
    logic restoreValid;
    pcs_pkg::pcs_ind_t ind;
    logic indWr;
    logic indMapped;
    logic [7:0] indRdata;
    logic indDone;
    logic indBusy;
    logic [11:0] dataAddr;
    logic dataRe;
    logic dataWe;
    logic [7:0] dataWdata;
    logic [14:0] progAddr;
    logic progRe;
    logic progHef;
    logic awready;
    logic wready;
    logic awHeld;
    logic [7:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pcs_top_t;

  pcs_top_t s;
  pcs_top_t next_s;

  logic stkPush;
  logic stkPop;
  logic [14:0] stkPushData;
  logic [14:0] stkTop;
  logic [4:0] stkDepth;
  logic stkOvfEv;
  logic stkUnfEv;
  logic [SW-1:0] shadow;
  logic [15:0] selPtr;

  // Fold an address into the implemented program space
  function automatic logic [14:0] wrapPc(input logic [14:0] a);
    return a & PC_MASK;
  endfunction

  // Linear GPR window to banked data address
  function automatic logic [11:0] linToBanked(input logic [15:0] p);
    logic [11:0] off;
    logic [11:0] bank;
    logic [11:0] idx;
    off = 12'(p - pcs_pkg::LIN_BASE);
    bank = off / pcs_pkg::GPR_BANK_BYTES;
    idx = off % pcs_pkg::GPR_BANK_BYTES;
    return {bank[4:0], 7'(idx[6:0] + pcs_pkg::GPR_BANK_OFFSET)};
  endfunction

  // Byte-lane merge of a write into a register value
  function automatic logic [31:0] applyStrb(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8+:8] = nw[i*8+:8];
      end
    end
    return r;
  endfunction

  // Register read value, top bit marks a mapped offset
  function automatic logic [32:0] regValue(input pcs_top_t st, input logic [7:0] a,
                                           input logic [4:0] dep);
    logic [32:0] v;
    v = {1'b1, 32'h0000_0000};
    case ({a[7:2], 2'b00})
      pcs_pkg::REG_CTRL: v[pcs_pkg::CTRL_STKRST_BIT] = st.stkRstEn;
      pcs_pkg::REG_PWR_STATUS: begin
        v[pcs_pkg::PWR_OVF_BIT] = st.ovf;
        v[pcs_pkg::PWR_UNF_BIT] = st.unf;
      end
      pcs_pkg::REG_PC: v[14:0] = st.pc;
      pcs_pkg::REG_PTR0: v[15:0] = st.ptr0;
      pcs_pkg::REG_PTR1: v[15:0] = st.ptr1;
      pcs_pkg::REG_IRQ_STATUS: v[2:0] = st.irqStat;
      pcs_pkg::REG_IRQ_MASK: v[2:0] = st.irqMask;
      pcs_pkg::REG_STACK_DEPTH: v[4:0] = dep;
      default: v[32] = 1'b0;
    endcase
    return v;
  endfunction

  // Stack requests: interrupt entry wins over any other op
  assign stkPush = intTake || opCall;
  assign stkPop = !intTake && (opReturn || opRetfie);
  assign stkPushData = intTake ? s.pc : wrapPc(15'(s.pc + 15'h0001));
  assign selPtr = indSel ? s.ptr1 : s.ptr0;

  pcs_return_stack #(
    .W(pcs_pkg::PC_W),
    .DEPTH(pcs_pkg::STACK_DEPTH)
  ) uStack (
    .clock(clock),
    .rst(rst),
    .clear(s.softReset),
    .push(stkPush),
    .pop(stkPop),
    .pushData(stkPushData),
    .top(stkTop),
    .depth(stkDepth),
    .overflow(stkOvfEv),
    .underflow(stkUnfEv)
  );

  pcs_shadow_ctx #(
    .W(SW)
  ) uShadow (
    .clock(clock),
    .rst(rst),
    .save(intTake),
    .saveData({ctxCore, s.ptr0, s.ptr1}),
    .shadow(shadow)
  );

  // Next-state logic: bus first, hardware events last so sets win
  always_comb begin
    logic [32:0] rv;
    logic [31:0] wv;
    logic stkErr;
    rv = '0;
    wv = '0;
    stkErr = 1'b0;
    next_s = s;
    next_s.softReset = 1'b0;
    next_s.restoreValid = 1'b0;
    next_s.indDone = 1'b0;
    // Write channel: address and data taken in either order
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    if (awvalid && s.awready) begin
      next_s.awHeld = 1'b1;
      next_s.awAddr = awaddr;
    end
    if (wvalid && s.wready) begin
      next_s.wHeld = 1'b1;
      next_s.wData = wdata;
      next_s.wStrb = wstrb;
    end
    if (next_s.awHeld && next_s.wHeld && !next_s.bvalid) begin
      rv = regValue(s, next_s.awAddr, stkDepth);
      wv = applyStrb(rv[31:0], next_s.wData, next_s.wStrb);
      next_s.bvalid = 1'b1;
      next_s.bresp = rv[32] ? pcs_pkg::RESP_OKAY : pcs_pkg::RESP_SLVERR;
      next_s.awHeld = 1'b0;
      next_s.wHeld = 1'b0;
      case ({next_s.awAddr[7:2], 2'b00})
        pcs_pkg::REG_CTRL: next_s.stkRstEn = wv[pcs_pkg::CTRL_STKRST_BIT];
        pcs_pkg::REG_PWR_STATUS: begin
          next_s.ovf = s.ovf & wv[pcs_pkg::PWR_OVF_BIT];
          next_s.unf = s.unf & wv[pcs_pkg::PWR_UNF_BIT];
        end
        pcs_pkg::REG_PTR0: next_s.ptr0 = wv[15:0];
        pcs_pkg::REG_PTR1: next_s.ptr1 = wv[15:0];
        pcs_pkg::REG_IRQ_MASK: next_s.irqMask = wv[2:0];
        default: next_s.bresp = next_s.bresp;
      endcase
    end
    next_s.awready = !next_s.awHeld && !next_s.bvalid;
    next_s.wready = !next_s.wHeld && !next_s.bvalid;
    // Read channel, interrupt status register clears on read
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    if (arvalid && s.arready) begin
      rv = regValue(s, araddr, stkDepth);
      next_s.rvalid = 1'b1;
      next_s.rdata = rv[31:0];
      next_s.rresp = rv[32] ? pcs_pkg::RESP_OKAY : pcs_pkg::RESP_SLVERR;
      if ({araddr[7:2], 2'b00} == pcs_pkg::REG_IRQ_STATUS) begin
        next_s.irqStat = '0;
      end
    end
    next_s.arready = !next_s.rvalid;
    // Stack error flags and optional reset
    if (stkOvfEv) begin
      next_s.ovf = 1'b1;
      next_s.irqStat[pcs_pkg::IRQ_OVF_BIT] = 1'b1;
    end
    if (stkUnfEv) begin
      next_s.unf = 1'b1;
      next_s.irqStat[pcs_pkg::IRQ_UNF_BIT] = 1'b1;
    end
    stkErr = (stkOvfEv || stkUnfEv) && s.stkRstEn;
    next_s.softReset = stkErr;
    // Program counter sequencing
    if (stkErr) begin
      next_s.pc = pcs_pkg::RESET_VEC;
    end else if (intTake) begin
      next_s.pc = pcs_pkg::INT_VEC;
    end else if (opCall || opBranch) begin
      next_s.pc = wrapPc(branchTarget);
    end else if (opReturn || opRetfie) begin
      next_s.pc = wrapPc(stkTop);
    end else if (opNext) begin
      next_s.pc = wrapPc(15'(s.pc + 15'h0001));
    end
    // Context restore on return from interrupt
    if (opRetfie && !intTake) begin
      next_s.restoreCore = shadow[SW-1:2*pcs_pkg::PTR_W];
      next_s.ptr0 = shadow[2*pcs_pkg::PTR_W-1:pcs_pkg::PTR_W];
      next_s.ptr1 = shadow[pcs_pkg::PTR_W-1:0];
      next_s.restoreValid = 1'b1;
    end
    // Indirect access sequencer
    case (s.ind)
      pcs_pkg::IND_IDLE: begin
        if (indReq) begin
          next_s.indWr = indWrite;
          if (selPtr[pcs_pkg::PROG_SEL_BIT]) begin
            next_s.progAddr = wrapPc(selPtr[14:0]);
            next_s.progRe = !indWrite;
            next_s.progHef = wrapPc(selPtr[14:0]) >= HEF_START;
            next_s.ind = pcs_pkg::IND_PWAIT;
          end else begin
            next_s.indMapped = 1'b1;
            if (selPtr <= pcs_pkg::TRAD_LAST) begin
              next_s.dataAddr = selPtr[11:0];
            end else if (selPtr >= pcs_pkg::LIN_BASE && selPtr <= pcs_pkg::LIN_LAST) begin
              next_s.dataAddr = linToBanked(selPtr);
            end else begin
              next_s.indMapped = 1'b0;
            end
            next_s.dataRe = next_s.indMapped && !indWrite;
            next_s.dataWe = next_s.indMapped && indWrite;
            next_s.dataWdata = indWdata;
            next_s.ind = pcs_pkg::IND_DATA;
          end
        end
      end
      pcs_pkg::IND_DATA: begin
        if (!s.indWr) begin
          next_s.indRdata = s.indMapped ? dataRdata : 8'h00;
        end
        next_s.dataRe = 1'b0;
        next_s.dataWe = 1'b0;
        next_s.indDone = 1'b1;
        next_s.ind = pcs_pkg::IND_IDLE;
      end
      pcs_pkg::IND_PWAIT: begin
        next_s.progRe = 1'b0;
        next_s.ind = pcs_pkg::IND_PCAP;
      end
      pcs_pkg::IND_PCAP: begin
        if (s.indWr) begin
          next_s.irqStat[pcs_pkg::IRQ_PWRITE_BIT] = 1'b1;
        end else begin
          next_s.indRdata = progData[7:0];
        end
        next_s.indDone = 1'b1;
        next_s.ind = pcs_pkg::IND_IDLE;
      end
      default: next_s.ind = pcs_pkg::IND_IDLE;
    endcase
    next_s.indBusy = next_s.ind != pcs_pkg::IND_IDLE;
    next_s.irq = |(next_s.irqStat & next_s.irqMask);
  end

  // State register
  always_ff @(posedge clock) begin
    if (rst) begin
      s <= '0;
      s.pc <= pcs_pkg::RESET_VEC;
      s.stkRstEn <= pcs_pkg::CTRL_RST;
      s.ptr0 <= pcs_pkg::PTR_RST;
      s.ptr1 <= pcs_pkg::PTR_RST;
      s.irqMask <= pcs_pkg::IRQ_MASK_RST;
      s.ind <= pcs_pkg::IND_IDLE;
      s.bresp <= pcs_pkg::RESP_OKAY;
      s.rresp <= pcs_pkg::RESP_OKAY;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from state
  assign awready = s.awready;
  assign wready = s.wready;
  assign bresp = s.bresp;
  assign bvalid = s.bvalid;
  assign arready = s.arready;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign rvalid = s.rvalid;
  assign restoreCore = s.restoreCore;
  assign restoreValid = s.restoreValid;
  assign pc = s.pc;
  assign indRdata = s.indRdata;
  assign indDone = s.indDone;
  assign indBusy = s.indBusy;
  assign dataAddr = s.dataAddr;
  assign dataRe = s.dataRe;
  assign dataWe = s.dataWe;
  assign dataWdata = s.dataWdata;
  assign progAddr = s.progAddr;
  assign progRe = s.progRe;
  assign progHef = s.progHef;
  assign softReset = s.softReset;
  assign irq = s.irq;

  // Checks
  property p_reset_vector;
    @(posedge clock) disable iff (rst) $fell(rst) |-> s.pc == 15'h0000 && stkDepth == 5'd0;
  endproperty
  a_reset_vector: assert property (p_reset_vector) else $error("pc not at reset vector");

  property p_int_vector;
    @(posedge clock) disable iff (rst) intTake && !stkOvfEv |=> s.pc == 15'h0004;
  endproperty
  a_int_vector: assert property (p_int_vector) else $error("interrupt vector missed");

  property p_ovf_flag;
    @(posedge clock) disable iff (rst) stkPush && stkDepth == 5'd16 |=> s.ovf && stkDepth == 5'd16;
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set");

  property p_unf_flag;
    @(posedge clock) disable iff (rst) stkPop && stkDepth == 5'd0 |=> s.unf;
  endproperty
  a_unf_flag: assert property (p_unf_flag) else $error("underflow flag not set");

  property p_stack_reset;
    @(posedge clock) disable iff (rst)
      (stkOvfEv || stkUnfEv) && s.stkRstEn |=> s.softReset && s.pc == 15'h0000 ##1 stkDepth == 5'd0;
  endproperty
  a_stack_reset: assert property (p_stack_reset) else $error("stack error reset missing");

  property p_restore;
    @(posedge clock) disable iff (rst)
      opRetfie && !intTake |=> restoreValid && restoreCore == $past(shadow[SW-1:32]);
  endproperty
  a_restore: assert property (p_restore) else $error("context not restored");

  property p_prog_timing;
    @(posedge clock) disable iff (rst)
      indReq && s.ind == pcs_pkg::IND_IDLE && selPtr[15] |=> !indDone [*2] ##1 indDone;
  endproperty
  a_prog_timing: assert property (p_prog_timing) else $error("program access timing wrong");

  property p_data_timing;
    @(posedge clock) disable iff (rst)
      indReq && s.ind == pcs_pkg::IND_IDLE && !selPtr[15] |=> !indDone ##1 indDone;
  endproperty
  a_data_timing: assert property (p_data_timing) else $error("data access timing wrong");

  property p_prog_no_write;
    @(posedge clock) disable iff (rst) indReq && indWrite && s.ind == pcs_pkg::IND_IDLE
      && selPtr[15] |=> !dataWe && !progRe [*3];
  endproperty
  a_prog_no_write: assert property (p_prog_no_write) else $error("program write took effect");

  property p_linear_map;
    @(posedge clock) disable iff (rst)
      indReq && s.ind == pcs_pkg::IND_IDLE && selPtr == 16'h2055 |=> dataAddr == 12'h0a5;
  endproperty
  a_linear_map: assert property (p_linear_map) else $error("linear GPR mapping wrong");

  property p_pc_wrap;
    @(posedge clock) disable iff (rst) (s.pc & ~PC_MASK) == 15'h0000;
  endproperty
  a_pc_wrap: assert property (p_pc_wrap) else $error("pc outside program memory");
endmodule // pcs_seq_unit
`default_nettype wire

// File: testbench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin nFail++; \
  $display("FAIL t=%0t got %h exp %h", $time, a, e); end end
module testbench;
  logic clock, rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid;
  logic rready, intTake, opCall, opBranch, opReturn, opRetfie, opNext, restoreValid, indReq;
  logic indWrite, indSel, indDone, indBusy, dataRe, dataWe, progRe, progHef, softReset, irq, we;
  logic [7:0] awaddr, araddr, indWdata, indRdata, dataWdata;
  logic [31:0] wdata, rdata, rd;
  logic hef;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [14:0] branchTarget, pc, progAddr, pa;
  logic [24:0] ctxCore, restoreCore;
  logic [11:0] dataAddr, da;
  int nFail, checked, cyc, n;
  localparam logic [5:0] INT = 6'h20, CALL = 6'h10, BR = 6'h08, RET = 6'h04, RFI = 6'h02;
  pcs_seq_unit #(.LARGE_VARIANT(1'b1)) dut (.clock, .rst, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .opNext, .opBranch, .opCall, .opReturn, .opRetfie, .intTake,
    .branchTarget, .ctxCore, .restoreCore, .restoreValid, .pc, .indReq, .indWrite, .indSel,
    .indWdata, .indRdata, .indDone, .indBusy, .dataAddr, .dataRe, .dataWe, .dataWdata,
    .dataRdata(8'h96), .progAddr, .progRe, .progHef, .progData(14'h3a5c), .softReset, .irq);
  // Clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Hang guard
  always @(posedge clock) begin
    n++;
    if (n == 20000) begin
      nFail++;
      end_sim;
    end
  end
  task automatic end_sim;
    $display("checked %0d nFail %0d", checked, nFail);
    if (nFail == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Register write, both channels offered together
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    {awaddr, wdata, wstrb} <= {a, d, 4'hf};
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask
  // Register read
  task automatic axr(input logic [7:0] a);
    @(posedge clock);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    rd = rdata;
  endtask
  // One decoder op, then one cycle for the result
  task automatic op(input logic [5:0] k, input logic [14:0] t);
    {intTake, opCall, opBranch, opReturn, opRetfie, opNext} <= k;
    branchTarget <= t;
    @(posedge clock);
    {intTake, opCall, opBranch, opReturn, opRetfie, opNext} <= 6'h0;
    @(posedge clock);
  endtask
  // Indirect access, counting cycles to completion
  task automatic ind(input logic s, input logic w);
    @(posedge clock);
    {indSel, indWrite, indReq} <= {s, w, 1'b1};
    cyc = 0;
    we = 1'b0;
    @(posedge clock);
    indReq <= 1'b0;
    do begin
      @(posedge clock);
      cyc++;
      we |= dataWe;
      if (progRe) pa = progAddr;
      if (progRe) hef = progHef;
      if (dataRe) da = dataAddr;
    end while (!indDone);
  endtask
  // Vectors, wrap, call and interrupt return
  task automatic t_pc;
    `CHK(pc, 15'h0000)
    op(BR, 15'h7abc);
    `CHK(pc, 15'h1abc)
    op(BR, 15'h1fff);
    op(6'h01, 15'h0);
    `CHK(pc, 15'h0000)
    op(CALL, 15'h0100);
    op(RET, 15'h0);
    `CHK(pc, 15'h0001)
    op(INT, 15'h0);
    `CHK(pc, 15'h0004)
    op(RFI, 15'h0);
    `CHK(pc, 15'h0001)
    `CHK(restoreCore, 25'h1abcdef)
    `CHK(restoreValid, 1'b1)
  endtask
  // Overflow, underflow, flags and stack reset
  task automatic t_stack;
    axw(pcs_pkg::REG_IRQ_MASK, 32'h7);
    repeat (17) op(CALL, 15'h0200);
    axr(pcs_pkg::REG_STACK_DEPTH);
    `CHK(rd, 32'h10)
    `CHK(irq, 1'b1)
    axr(pcs_pkg::REG_IRQ_STATUS);
    `CHK(rd, 32'h1)
    `CHK(irq, 1'b0)
    repeat (17) op(RET, 15'h0);
    `CHK(pc, 15'h0000)
    axr(pcs_pkg::REG_PWR_STATUS);
    `CHK(rd, 32'h3)
    axw(pcs_pkg::REG_CTRL, 32'h1);
    repeat (17) op(CALL, 15'h0300);
    `CHK(softReset, 1'b1)
    `CHK(pc, 15'h0000)
    axr(pcs_pkg::REG_STACK_DEPTH);
    `CHK(rd, 32'h0)
    axr(pcs_pkg::REG_IRQ_STATUS);
    `CHK(rd, 32'h3)
  endtask
  // Program, linear and refused indirect accesses
  task automatic t_ind;
    axw(pcs_pkg::REG_PTR0, 32'h8005);
    ind(1'b0, 1'b0);
    `CHK(cyc, 3)
    `CHK(pa, 15'h0005)
    `CHK(hef, 1'b0)
    `CHK(indRdata, 8'h5c)
    axw(pcs_pkg::REG_PTR0, 32'hff85);
    ind(1'b0, 1'b0);
    `CHK(pa, 15'h1f85)
    `CHK(hef, 1'b1)
    axw(pcs_pkg::REG_PTR1, 32'h2055);
    `CHK(bresp, pcs_pkg::RESP_OKAY)
    ind(1'b1, 1'b0);
    `CHK(cyc, 2)
    `CHK(da, 12'h0a5)
    `CHK(indRdata, 8'h96)
    ind(1'b1, 1'b1);
    `CHK(we, 1'b1)
    `CHK(dataWdata, 8'h77)
    ind(1'b0, 1'b1);
    `CHK(we, 1'b0)
    axr(pcs_pkg::REG_IRQ_STATUS);
    `CHK(rd, 32'h4)
    axr(8'h40);
    `CHK(rresp, pcs_pkg::RESP_SLVERR)
    `CHK(rd, 32'h0)
    axw(8'h40, 32'h1);
    `CHK(bresp, pcs_pkg::RESP_SLVERR)
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, indReq, indWrite, indSel} = 8'h0;
    {intTake, opCall, opBranch, opReturn, opRetfie, opNext} = 6'h0;
    {awaddr, araddr, wdata, wstrb, branchTarget} = '0;
    indWdata = 8'h77;
    ctxCore = 25'h1abcdef;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    t_pc;
    t_stack;
    t_ind;
    end_sim;
  end
endmodule // testbench
`default_nettype wire
